// file: design/break_unit_pkg.sv
// package of the two-channel hardware breakpoint unit
// assumes a 32-bit axi4-lite register bus and one system clock
//
// Summary of operation
// - two channels, each may break alone
// - sequential mode: A match, then B
// - address compare all, low 10, 12, none
// - space id compared fully or not
// - channel B only: masked 32-bit data compare
// - data compare only with data break enable
// - cycle: fetch/data, read/write, operand size
// - fetch break before or after execution
// - satisfied conditions raise the user break trap while both match flags are clear
// - break sets matching channel's match flag; a sequential break sets both flags
// - resets clear cycle selects and control
// - registers hold their contents in standby
// - address registers survive manual reset
// - zero cycle field drops that attribute
// - data ignored for fetch-only cycle select or disabled data
package break_unit_pkg;
    // register byte addresses
    localparam logic [31:0] OFS_CONTROL = 32'h0fff_ff98;
    localparam logic [31:0] OFS_ADDR_A = 32'h0fff_ffb0;
    localparam logic [31:0] OFS_AMASK_A = 32'h0fff_ffb4;
    localparam logic [31:0] OFS_CYCLE_A = 32'h0fff_ffb8;
    localparam logic [31:0] OFS_SID_A = 32'h0fff_ffe4;
    localparam logic [31:0] OFS_SID_B = 32'h0fff_ffe8;
    localparam logic [31:0] OFS_DATA_B = 32'hffff_ff90;
    localparam logic [31:0] OFS_DMASK_B = 32'hffff_ff94;
    localparam logic [31:0] OFS_ADDR_B = 32'hffff_ffa0;
    localparam logic [31:0] OFS_AMASK_B = 32'hffff_ffa4;
    localparam logic [31:0] OFS_CYCLE_B = 32'hffff_ffa8;
    localparam logic [31:0] OFS_IRQ_STATUS = 32'hffff_ffc0;
    localparam logic [31:0] OFS_IRQ_MASK = 32'hffff_ffc4;
    // control register bit positions
    localparam int CTL_FLAG_A_BIT = 15;
    localparam int CTL_FLAG_B_BIT = 14;
    localparam int CTL_TIMING_A_BIT = 7;
    localparam int CTL_DATA_EN_BIT = 6;
    localparam int CTL_TIMING_B_BIT = 5;
    localparam int CTL_SEQ_MODE_BIT = 3;
    // address mask register fields
    localparam int AMASK_SID_BIT = 2;
    localparam logic [1:0] AMSEL_ALL = 2'h0;
    localparam logic [1:0] AMSEL_LOW10 = 2'h1;
    localparam logic [1:0] AMSEL_LOW12 = 2'h2;
    localparam logic [31:0] KEEP_ABOVE_10 = 32'hffff_fc00;
    localparam logic [31:0] KEEP_ABOVE_12 = 32'hffff_f000;
    // cycle select fields: id [5:4], rw [3:2], size [1:0]
    localparam int CYC_ID_LSB = 4;
    localparam int CYC_RW_LSB = 2;
    localparam logic [1:0] ID_FETCH_ONLY = 2'h1;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [31:0] LANES_BYTE = 32'h0000_00ff;
    localparam logic [31:0] LANES_WORD = 32'h0000_ffff;
    // reset values
    localparam logic [5:0] RST_CYCLE = 6'h00;
    localparam logic [15:0] RST_CONTROL = 16'h0000;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // sequential chain state
    typedef enum logic [1:0] {ARM_IDLE = 2'b01, ARM_SET = 2'b10} chain_t;

    // byte-lane merge of a register write
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        end
        return r;
    endfunction : merge_bytes
endpackage : break_unit_pkg

// file: design/break_channel_match.sv
// one break channel comparator, purely combinational
// assumes cpu cycle signals and settings on the same clock
`timescale 1ns/1ps
module break_channel_match
    import break_unit_pkg::*;
#(
    parameter bit HAS_DATA = 1'b0
)(
    input wire logic bus_valid,
    input wire logic [31:0] bus_addr,
    input wire logic [7:0] bus_address_space_identifier,
    input wire logic bus_fetch,
    input wire logic bus_write,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_data,
    input wire logic [31:0] cfg_addr,
    input wire logic [2:0] cfg_amask,
    input wire logic [7:0] cfg_sid,
    input wire logic [5:0] cfg_cycle,
    input wire logic [31:0] cfg_data,
    input wire logic [31:0] cfg_dmask,
    input wire logic data_en,
    output logic match
);
    logic [31:0] akeep;
    logic [31:0] dkeep;
    logic [1:0] id_sel;
    logic [1:0] rw_sel;
    logic [1:0] sz_sel;
    logic addr_ok;
    logic sid_ok;
    logic cyc_ok;
    logic data_ok;

    // address and space id compare
    always_comb
    begin
        unique case (cfg_amask[1:0])
            AMSEL_ALL: akeep = '1;
            AMSEL_LOW10: akeep = KEEP_ABOVE_10;
            AMSEL_LOW12: akeep = KEEP_ABOVE_12;
            default: akeep = '0;
        endcase
        addr_ok = ((bus_addr ^ cfg_addr) & akeep) == '0;
        sid_ok = cfg_amask[AMASK_SID_BIT] || (bus_address_space_identifier == cfg_sid);
    end

    // cycle type, direction, size; zero field means not compared
    always_comb
    begin
        id_sel = cfg_cycle[CYC_ID_LSB +: 2];
        rw_sel = cfg_cycle[CYC_RW_LSB +: 2];
        sz_sel = cfg_cycle[1:0];
        cyc_ok = (id_sel == '0 || (bus_fetch ? id_sel[0] : id_sel[1])) &&
                 (rw_sel == '0 || (bus_write ? rw_sel[1] : rw_sel[0])) &&
                 (sz_sel == '0 || sz_sel == bus_size);
    end

    // masked data compare, only for the data channel
    always_comb
    begin
        unique case (bus_size)
            SIZE_BYTE: dkeep = ~cfg_dmask & LANES_BYTE;
            SIZE_WORD: dkeep = ~cfg_dmask & LANES_WORD;
            default: dkeep = ~cfg_dmask;
        endcase
        data_ok = !HAS_DATA || !data_en || id_sel == ID_FETCH_ONLY ||
                  ((bus_data ^ cfg_data) & dkeep) == '0;
    end

    // every enabled condition within the same cycle
    assign match = bus_valid && addr_ok && sid_ok && cyc_ok && data_ok;
endmodule : break_channel_match

// file: design/user_break_unit.sv
// two-channel breakpoint unit with axi4-lite registers and interrupt
// assumes cpu cycle inputs on clk_sys, manual_reset a synchronous pulse
`timescale 1ns/1ps
module user_break_unit
    import break_unit_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic manual_reset,
    // cpu bus cycle being watched
    input wire logic cpu_valid,
    input wire logic [31:0] cpu_addr,
    input wire logic [7:0] cpu_address_space_identifier,
    input wire logic cpu_fetch,
    input wire logic cpu_write,
    input wire logic [1:0] cpu_size,
    input wire logic [31:0] cpu_data,
    // axi4-lite slave
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // break trap and interrupt
    output logic user_break,
    output logic break_after_exec,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic [31:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [31:0] addr_a;
        logic [31:0] addr_b;
        logic [2:0] amask_a;
        logic [2:0] amask_b;
        logic [7:0] sid_a;
        logic [7:0] sid_b;
        logic [5:0] cycle_a;
        logic [5:0] cycle_b;
        logic [31:0] data_b;
        logic [31:0] dmask_b;
        logic flag_a;
        logic flag_b;
        logic timing_a;
        logic timing_b;
        logic data_en;
        logic seq_mode;
        chain_t chain;
        logic brk;
        logic brk_after;
        logic [1:0] ist;
        logic [1:0] imask;
        logic irq;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic match_a;
    logic match_b;
    logic wr_fire;
    logic [15:0] ctl_rd;

    ////////////////////////////////////////////////////////////////////
    // channel comparators
    break_channel_match #(.HAS_DATA(1'b0)) u_match_a (
        .bus_valid(cpu_valid),
        .bus_addr(cpu_addr),
        .bus_address_space_identifier(cpu_address_space_identifier),
        .bus_fetch(cpu_fetch),
        .bus_write(cpu_write),
        .bus_size(cpu_size),
        .bus_data(cpu_data),
        .cfg_addr(s_q.addr_a),
        .cfg_amask(s_q.amask_a),
        .cfg_sid(s_q.sid_a),
        .cfg_cycle(s_q.cycle_a),
        .cfg_data('0),
        .cfg_dmask('0),
        .data_en(1'b0),
        .match(match_a)
    );

    break_channel_match #(.HAS_DATA(1'b1)) u_match_b (
        .bus_valid(cpu_valid),
        .bus_addr(cpu_addr),
        .bus_address_space_identifier(cpu_address_space_identifier),
        .bus_fetch(cpu_fetch),
        .bus_write(cpu_write),
        .bus_size(cpu_size),
        .bus_data(cpu_data),
        .cfg_addr(s_q.addr_b),
        .cfg_amask(s_q.amask_b),
        .cfg_sid(s_q.sid_b),
        .cfg_cycle(s_q.cycle_b),
        .cfg_data(s_q.data_b),
        .cfg_dmask(s_q.dmask_b),
        .data_en(s_q.data_en),
        .match(match_b)
    );

    // control register image
    always_comb
    begin
        ctl_rd = RST_CONTROL;
        ctl_rd[CTL_FLAG_A_BIT] = s_q.flag_a;
        ctl_rd[CTL_FLAG_B_BIT] = s_q.flag_b;
        ctl_rd[CTL_TIMING_A_BIT] = s_q.timing_a;
        ctl_rd[CTL_TIMING_B_BIT] = s_q.timing_b;
        ctl_rd[CTL_DATA_EN_BIT] = s_q.data_en;
        ctl_rd[CTL_SEQ_MODE_BIT] = s_q.seq_mode;
    end

    assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic [31:0] m;
        logic hit;
        logic set_a;
        logic set_b;
        logic idle;
        logic [1:0] clr;
        m = '0;
        hit = 1'b0;
        set_a = 1'b0;
        set_b = 1'b0;
        clr = '0;
        s_d = s_q;
        idle = !s_q.flag_a && !s_q.flag_b;

        // write address and data taken in either order
        if (awvalid && s_q.awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && s_q.wready)
        begin
            s_d.w_got = 1'b1;
            s_d.w_data = wvalid ? wdata : s_q.w_data;
            s_d.w_strb = wstrb;
        end
        if (s_q.bvalid && bready)
            s_d.bvalid = 1'b0;

        // register write
        if (wr_fire)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            unique case (s_q.aw_addr)
                OFS_CONTROL:
                begin
                    m = merge_bytes({16'h0000, ctl_rd}, s_q.w_data, s_q.w_strb);
                    s_d.flag_a = m[CTL_FLAG_A_BIT];
                    s_d.flag_b = m[CTL_FLAG_B_BIT];
                    s_d.timing_a = m[CTL_TIMING_A_BIT];
                    s_d.timing_b = m[CTL_TIMING_B_BIT];
                    s_d.data_en = m[CTL_DATA_EN_BIT];
                    s_d.seq_mode = m[CTL_SEQ_MODE_BIT];
                end
                OFS_ADDR_A: s_d.addr_a = merge_bytes(s_q.addr_a, s_q.w_data, s_q.w_strb);
                OFS_ADDR_B: s_d.addr_b = merge_bytes(s_q.addr_b, s_q.w_data, s_q.w_strb);
                OFS_AMASK_A:
                begin
                    m = merge_bytes({29'h0, s_q.amask_a}, s_q.w_data, s_q.w_strb);
                    s_d.amask_a = m[2:0];
                end
                OFS_AMASK_B:
                begin
                    m = merge_bytes({29'h0, s_q.amask_b}, s_q.w_data, s_q.w_strb);
                    s_d.amask_b = m[2:0];
                end
                OFS_SID_A:
                begin
                    m = merge_bytes({24'h0, s_q.sid_a}, s_q.w_data, s_q.w_strb);
                    s_d.sid_a = m[7:0];
                end
                OFS_SID_B:
                begin
                    m = merge_bytes({24'h0, s_q.sid_b}, s_q.w_data, s_q.w_strb);
                    s_d.sid_b = m[7:0];
                end
                OFS_CYCLE_A:
                begin
                    m = merge_bytes({26'h0, s_q.cycle_a}, s_q.w_data, s_q.w_strb);
                    s_d.cycle_a = m[5:0];
                end
                OFS_CYCLE_B:
                begin
                    m = merge_bytes({26'h0, s_q.cycle_b}, s_q.w_data, s_q.w_strb);
                    s_d.cycle_b = m[5:0];
                end
                OFS_DATA_B: s_d.data_b = merge_bytes(s_q.data_b, s_q.w_data, s_q.w_strb);
                OFS_DMASK_B: s_d.dmask_b = merge_bytes(s_q.dmask_b, s_q.w_data, s_q.w_strb);
                OFS_IRQ_STATUS:
                begin
                    m = merge_bytes('0, s_q.w_data, s_q.w_strb);
                    clr = m[1:0];
                end
                OFS_IRQ_MASK:
                begin
                    m = merge_bytes({30'h0, s_q.imask}, s_q.w_data, s_q.w_strb);
                    s_d.imask = m[1:0];
                end
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready = !s_d.w_got && !s_d.bvalid;

        // register read, answered the cycle after the address
        if (s_q.rvalid && rready)
            s_d.rvalid = 1'b0;
        if (arvalid && s_q.arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            unique case (araddr)
                OFS_CONTROL: s_d.rdata = {16'h0000, ctl_rd};
                OFS_ADDR_A: s_d.rdata = s_q.addr_a;
                OFS_ADDR_B: s_d.rdata = s_q.addr_b;
                OFS_AMASK_A: s_d.rdata = {29'h0, s_q.amask_a};
                OFS_AMASK_B: s_d.rdata = {29'h0, s_q.amask_b};
                OFS_SID_A: s_d.rdata = {24'h0, s_q.sid_a};
                OFS_SID_B: s_d.rdata = {24'h0, s_q.sid_b};
                OFS_CYCLE_A: s_d.rdata = {26'h0, s_q.cycle_a};
                OFS_CYCLE_B: s_d.rdata = {26'h0, s_q.cycle_b};
                OFS_DATA_B: s_d.rdata = s_q.data_b;
                OFS_DMASK_B: s_d.rdata = s_q.dmask_b;
                OFS_IRQ_STATUS: s_d.rdata = {30'h0, s_q.ist};
                OFS_IRQ_MASK: s_d.rdata = {30'h0, s_q.imask};
                default:
                begin
                    s_d.rdata = '0;
                    s_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        s_d.arready = !s_d.rvalid;

        // break decision, independent or chained
        s_d.brk_after = 1'b0;
        if (s_q.seq_mode)
        begin
            unique case (s_q.chain)
                ARM_IDLE:
                begin
                    if (match_a)
                        s_d.chain = ARM_SET;
                end
                ARM_SET:
                begin
                    if (match_b && idle)
                    begin
                        hit = 1'b1;
                        set_a = 1'b1;
                        set_b = 1'b1;
                        s_d.chain = ARM_IDLE;
                        s_d.brk_after = cpu_fetch && s_q.timing_b;
                    end
                end
                default: s_d.chain = ARM_IDLE;
            endcase
        end
        else
        begin
            s_d.chain = ARM_IDLE;
            if ((match_a || match_b) && idle)
            begin
                hit = 1'b1;
                set_a = match_a;
                set_b = match_b;
                s_d.brk_after = cpu_fetch && ((match_a && s_q.timing_a) || (match_b && s_q.timing_b));
            end
        end
        s_d.brk = hit;
        // hardware set wins over a software clear
        s_d.flag_a = s_d.flag_a || set_a;
        s_d.flag_b = s_d.flag_b || set_b;
        s_d.ist = (s_q.ist & ~clr) | {set_b, set_a};

        // manual reset clears cycle selects, control, chain state and break outputs; addresses kept
        if (manual_reset)
        begin
            s_d.cycle_a = RST_CYCLE;
            s_d.cycle_b = RST_CYCLE;
            s_d.flag_a = RST_CONTROL[CTL_FLAG_A_BIT];
            s_d.flag_b = RST_CONTROL[CTL_FLAG_B_BIT];
            s_d.timing_a = RST_CONTROL[CTL_TIMING_A_BIT];
            s_d.timing_b = RST_CONTROL[CTL_TIMING_B_BIT];
            s_d.data_en = RST_CONTROL[CTL_DATA_EN_BIT];
            s_d.seq_mode = RST_CONTROL[CTL_SEQ_MODE_BIT];
            s_d.chain = ARM_IDLE;
            s_d.brk = 1'b0;
            s_d.brk_after = 1'b0;
            s_d.ist = s_q.ist & ~clr; // suppressed break raises no event
        end
        s_d.irq = |(s_d.ist & s_d.imask);
    end

    ////////////////////////////////////////////////////////////////////
    // registers; no clock gating, so everything holds in standby
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            s_q <= '0;
            s_q.chain <= ARM_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rresp = s_q.rresp;
    assign rdata = s_q.rdata;
    assign user_break = s_q.brk;
    assign break_after_exec = s_q.brk_after;
    assign irq = s_q.irq;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_break_single: assert property (user_break |=> !user_break)
        else $error("break repeated without flag clear");
    a_flags_block: assert property ((s_q.flag_a || s_q.flag_b) |=> !user_break)
        else $error("break while a match flag was set");
    a_flag_on_break: assert property (user_break |-> (s_q.flag_a || s_q.flag_b))
        else $error("break without match flag");
    a_indep_break: assert property (!s_q.seq_mode && !manual_reset && match_a && !s_q.flag_a && !s_q.flag_b
        |=> user_break && s_q.flag_a)
        else $error("channel A match gave no break");
    a_chain_order: assert property ($past(s_q.seq_mode) && user_break |-> $past(s_q.chain) == ARM_SET)
        else $error("chained break without channel A first");
    a_manual_clear: assert property (manual_reset |=> s_q.cycle_a == RST_CYCLE && s_q.cycle_b == RST_CYCLE
        && ctl_rd == RST_CONTROL)
        else $error("manual reset left cycle or control set");
    a_addr_keep: assert property (manual_reset && !wr_fire |=> $stable(s_q.addr_a) && $stable(s_q.addr_b))
        else $error("address lost on manual reset");
    a_irq_follow: assert property (user_break && (&s_q.imask) |-> irq)
        else $error("interrupt missing after break");
    a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");

    c_indep: cover property (!s_q.seq_mode ##0 user_break);
    c_chain: cover property (s_q.seq_mode && s_q.chain == ARM_SET ##[1:20] user_break);
    c_after: cover property (break_after_exec);
    c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
endmodule : user_break_unit

// file: dv/cpu_cycle_model.sv
// cpu bus cycle source watched by the breakpoint unit
// assumes the bench calls cycle() and owns clk_sys
`timescale 1ns/1ps
module cpu_cycle_model (
    input wire logic clk_sys,
    output logic cpu_valid,
    output logic [31:0] cpu_addr,
    output logic [7:0] cpu_address_space_identifier,
    output logic cpu_fetch,
    output logic cpu_write,
    output logic [1:0] cpu_size,
    output logic [31:0] cpu_data
);
    // bus idle until the first cycle
    initial {cpu_valid, cpu_addr, cpu_address_space_identifier, cpu_fetch, cpu_write, cpu_size, cpu_data} = '0;

    ////////////////////////////////////////////////////////////////
    // one bus cycle; fws is fetch, write, size
    task automatic cycle(input logic [31:0] a, input logic [7:0] s, input logic [3:0] fws, input logic [31:0] d);
        @(posedge clk_sys);
        cpu_valid <= 1'b1;
        {cpu_addr, cpu_address_space_identifier, cpu_fetch, cpu_write, cpu_size, cpu_data} <= {a, s, fws, d};
        @(posedge clk_sys);
        cpu_valid <= 1'b0;
        // released lines show the inverse, never the old value
        {cpu_addr, cpu_address_space_identifier, cpu_fetch, cpu_write, cpu_size, cpu_data} <= ~{a, s, fws, d};
        repeat (3) @(posedge clk_sys);
    endtask : cycle
endmodule : cpu_cycle_model

// file: dv/user_break_unit_bench.sv
// self-checking bench of the two-channel breakpoint unit
// assumes the design package and the cpu cycle model are compiled first
`timescale 1ns/1ps
module user_break_unit_bench;
    import break_unit_pkg::*;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
    logic clk_sys, reset, manual_reset, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cpu_valid, cpu_fetch, cpu_write, user_break, break_after_exec, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, cpu_addr, cpu_data, exp_v;
    logic [7:0] cpu_address_space_identifier;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, cpu_size;
    logic exp_b;
    logic [1:0] exp_r;
    logic [31:0] rd_q[$];
    logic brk_q[$];
    logic [1:0] rr_q[$], br_q[$];
    int miscompares, tests_run, seed;

    user_break_unit uut (.clk_sys, .reset, .manual_reset, .cpu_valid, .cpu_addr, .cpu_address_space_identifier, .cpu_fetch,
        .cpu_write, .cpu_size, .cpu_data, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .user_break, .break_after_exec, .irq);
    cpu_cycle_model cpu (.clk_sys, .cpu_valid, .cpu_addr, .cpu_address_space_identifier, .cpu_fetch, .cpu_write, .cpu_size, .cpu_data);

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////
    // compare each result with the oldest note
    always @(posedge clk_sys)
    begin
        if (rvalid && rready)
        begin
            exp_v = rd_q.size() ? rd_q.pop_front() : 'x;
            `CHK("rdata", exp_v, rdata)
            exp_r = rr_q.size() ? rr_q.pop_front() : 2'bxx;
            `CHK("rresp", exp_r, rresp)
        end
        if (bvalid && bready)
        begin
            exp_r = br_q.size() ? br_q.pop_front() : 2'bxx;
            `CHK("bresp", exp_r, bresp)
        end
        if (user_break)
        begin
            exp_b = brk_q.size() ? brk_q.pop_front() : 1'bx;
            `CHK("break_after_exec", exp_b, break_after_exec)
        end
    end

    ////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic close_out(input bit hung);
        miscompares += hung;
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    // register write, address and data offered together
    task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        int n;
        br_q.push_back(r);
        @(posedge clk_sys);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        // byte and word registers written in their own access size
        wstrb <= (a inside {OFS_AMASK_A, OFS_AMASK_B, OFS_SID_A, OFS_SID_B}) ? 4'h1 :
            (a inside {OFS_CONTROL, OFS_CYCLE_A, OFS_CYCLE_B}) ? 4'h3 : 4'hf;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n >= 40) close_out(1'b1);
    endtask : axw

    // register read; the monitor checks the data
    task automatic axr(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
        int n;
        rd_q.push_back(e);
        rr_q.push_back(r);
        @(posedge clk_sys);
        {araddr, arvalid, rready} <= {a, 2'b11};
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n >= 40) close_out(1'b1);
    endtask : axr

    // cpu cycle; e is the expected timing bit, negative for no break
    task automatic hit(input logic [31:0] a, input logic [7:0] s, input logic [3:0] fws, input logic [31:0] d, input int e);
        if (e >= 0) brk_q.push_back(e[0]);
        cpu.cycle(a, s, fws, d);
    endtask : hit

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        seed = 32'h1e94;
        {reset, clk_sys, manual_reset, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hf;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        axr(OFS_CONTROL, 32'h0000_0000);
        axr(OFS_CYCLE_B, 32'h0000_0000);
        // channel A: fetch read longword, low 10 bits ignored, break after
        axw(OFS_ADDR_A, 32'h8000_1234);
        axw(OFS_AMASK_A, 32'h0000_0001);
        axw(OFS_SID_A, 32'h0000_005a);
        axw(OFS_CYCLE_A, 32'h0000_0017);
        axw(OFS_CONTROL, 32'h0000_0080);
        hit(32'h8000_13ff, 8'h5a, 4'hb, 32'h0000_0000, 1);
        axr(OFS_CONTROL, 32'h0000_8080);
        hit(32'h8000_13ff, 8'h5a, 4'hb, 32'h0000_0000, -1);
        axw(OFS_CONTROL, 32'h0000_0080);
        hit(32'h8000_1634, 8'h5a, 4'hb, 32'h0000_0000, -1);
        hit(32'h8000_1234, 8'h5b, 4'hb, 32'h0000_0000, -1);
        hit(32'h8000_1234, 8'h5a, 4'hf, 32'h0000_0000, -1);
        hit(32'h8000_1234, 8'h5a, 4'ha, 32'h0000_0000, -1);
        axw(OFS_AMASK_A, 32'h0000_0002);
        hit(32'h8000_1634, 8'h5a, 4'hb, 32'h0000_0000, 1);
        // channel B: data write longword, address and id left out, low byte masked
        axw(OFS_AMASK_B, 32'h0000_0007);
        axw(OFS_DATA_B, 32'hcafe_0011);
        axw(OFS_DMASK_B, 32'h0000_00ff);
        axw(OFS_CYCLE_B, 32'h0000_002b);
        axw(OFS_CONTROL, 32'h0000_0040);
        hit($random(seed), 8'($random(seed)), 4'h7, 32'hcafe_00ee, 0);
        axw(OFS_CONTROL, 32'h0000_0040);
        hit($random(seed), 8'($random(seed)), 4'h7, 32'hcaff_0011, -1);
        axw(OFS_CONTROL, 32'h0000_0000);
        hit($random(seed), 8'($random(seed)), 4'h7, 32'hcaff_0011, 0);
        axw(OFS_CONTROL, 32'h0000_0000);
        axw(OFS_CYCLE_B, 32'h0000_0020);
        hit($random(seed), 8'($random(seed)), 4'h1, 32'h0000_0000, 0);
        // sequential chain with the interrupt unmasked
        axw(OFS_IRQ_STATUS, 32'h0000_0003);
        axw(OFS_IRQ_MASK, 32'h0000_0003);
        axw(OFS_CONTROL, 32'h0000_0008);
        @(negedge clk_sys);
        `CHK("irq", 1'b0, irq)
        hit($random(seed), 8'h00, 4'h7, 32'h0000_0000, -1);
        hit(32'h8000_1234, 8'h5a, 4'hb, 32'h0000_0000, -1);
        hit($random(seed), 8'h00, 4'h7, 32'h0000_0000, 0);
        axr(OFS_CONTROL, 32'h0000_c008);
        @(negedge clk_sys);
        `CHK("irq", 1'b1, irq)
        axr(OFS_IRQ_STATUS, 32'h0000_0003);
        axw(OFS_IRQ_STATUS, 32'h0000_0003);
        repeat (2) @(negedge clk_sys);
        `CHK("irq", 1'b0, irq)
        // manual reset keeps addresses, clears conditions and control
        @(posedge clk_sys);
        manual_reset <= 1'b1;
        @(posedge clk_sys);
        manual_reset <= 1'b0;
        axr(OFS_CYCLE_A, 32'h0000_0000);
        axr(OFS_CONTROL, 32'h0000_0000);
        axr(OFS_ADDR_A, 32'h8000_1234);
        axw(32'hffff_ffd0, 32'h0000_0001, RESP_SLVERR);
        axr(32'hffff_ffd0, 32'h0000_0000, RESP_SLVERR);
        `CHK("breaks_left", 0, brk_q.size())
        close_out(1'b0);
    end
endmodule : user_break_unit_bench
